// ### rtl/scs_pkg.sv
// Shared constants and types of the system clock and standby controller.
package scs_pkg;
    // ----------------------------------------------------------------
    // Divider structure
    // ----------------------------------------------------------------
    localparam int PRESC_W = 2;
    localparam int LOW_STAGES = 6;
    localparam int HIGH_STAGES = 15;
    localparam int DIV_STAGES = LOW_STAGES + HIGH_STAGES;
    localparam logic [PRESC_W-1:0] PRESC_RST = 2'h0;
    localparam logic [LOW_STAGES-1:0] DIV_LOW_RST = 6'h00;
    localparam logic [HIGH_STAGES-1:0] DIV_HIGH_RST = 15'h0000;
    localparam int WARM_TAP = 4;
    // ----------------------------------------------------------------
    // Register fields
    // ----------------------------------------------------------------
    localparam int TBC_W = 8;
    localparam int DIVSRC_BIT = 4;
    localparam logic [TBC_W-1:0] TBC_RST = 8'h00;
    // ----------------------------------------------------------------
    // Machine cycle
    // ----------------------------------------------------------------
    localparam logic [1:0] LAST_STATE = 2'h3;
    localparam int LEN_W = 4;
    localparam logic [LEN_W-1:0] INSTR_MIN = 4'h1;
    localparam logic [LEN_W-1:0] INSTR_MAX = 4'hA;
    localparam logic [LEN_W-1:0] LEN_RST = 4'h0;
    // ----------------------------------------------------------------
    // Operating modes, Gray coded in the order they are listed
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        MODE_SINGLE_RUN  = 3'h0,
        MODE_SINGLE_HALT = 3'h1,
        MODE_DUAL_RUN    = 3'h3,
        MODE_DUAL_HALT   = 3'h2,
        MODE_SLOW        = 3'h6,
        MODE_SLEEP       = 3'h7,
        MODE_FULL_HALT   = 3'h5,
        MODE_WARMUP      = 3'h4
    } scs_mode_t;
endpackage : scs_pkg

// ### rtl/scs_link_if.sv
// Link between the clock controller and the CPU core side.
`timescale 1ns/1ns
interface scs_link_if
    import scs_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n
);
    logic [TBC_W-1:0] timeBaseCtrl;
    logic idleReq;
    logic stopReq;
    logic sysClkSel;
    logic lowOscEnable;
    logic wakeEdgeMode;
    logic stopFloat;
    logic intReq;
    logic intMasterEnable;
    logic instrGo;
    logic [LEN_W-1:0] instrLen;
    logic cpuRun;
    logic wdtRun;
    logic [1:0] cycleState;
    logic cycleEnd;
    logic instrDone;
    scs_mode_t mode;
    logic resumeNext;
    logic resumeIsr;

    modport dev (
        input clk, rst_n, timeBaseCtrl, idleReq, stopReq, sysClkSel, lowOscEnable,
        input wakeEdgeMode, stopFloat, intReq, intMasterEnable, instrGo, instrLen,
        output cpuRun, wdtRun, cycleState, cycleEnd, instrDone, mode, resumeNext,
        output resumeIsr
    );
    modport host (
        input clk, rst_n, cpuRun, wdtRun, cycleState, cycleEnd, instrDone, mode,
        input resumeNext, resumeIsr,
        output timeBaseCtrl, idleReq, stopReq, sysClkSel, lowOscEnable,
        output wakeEdgeMode, stopFloat, intReq, intMasterEnable, instrGo, instrLen
    );
endinterface : scs_link_if

// ### rtl/scs_device.sv
// Clock controller end: timing generator, machine cycle and standby modes.
`timescale 1ns/1ns
module scs_device
    import scs_pkg::*;
(
    scs_link_if.dev link,
    input wire logic dualOption,
    input wire logic lowFreqPin,
    input wire logic wakePin,
    output logic [DIV_STAGES-1:0] dividerTaps,
    output logic dividerOutputPulse,
    output logic highOscOn,
    output logic lowOscOn,
    output logic lowPinsAsPorts,
    output logic portsFloat
);
    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    logic [1:0] fsSync_ff;
    logic [1:0] wakeSync_ff;
    logic [1:0] optSync_ff;
    logic fsPrev_ff;
    logic wakePrev_ff;

    // Two flops per pin; edge detectors look only at the second stage.
    always_ff @(posedge link.clk or negedge link.rst_n) begin
        if (!link.rst_n) begin
            fsSync_ff <= 2'h0;
            wakeSync_ff <= 2'h0;
            optSync_ff <= 2'h0;
            fsPrev_ff <= 1'b0;
            wakePrev_ff <= 1'b0;
        end else begin
            fsSync_ff <= {fsSync_ff[0], lowFreqPin};
            wakeSync_ff <= {wakeSync_ff[0], wakePin};
            optSync_ff <= {optSync_ff[0], dualOption};
            fsPrev_ff <= fsSync_ff[1];
            wakePrev_ff <= wakeSync_ff[1];
        end
    end

    logic fsTick;
    logic wakeHit;
    assign fsTick = fsSync_ff[1] & ~fsPrev_ff;
    // Edge mode sees a rising edge; level mode sees a high pin.
    assign wakeHit = link.wakeEdgeMode ? (wakeSync_ff[1] & ~wakePrev_ff) : wakeSync_ff[1];

    // ----------------------------------------------------------------
    // Mode state
    // ----------------------------------------------------------------
    scs_mode_t mode_ff, nxt_mode;
    scs_mode_t retMode_ff, nxt_retMode;
    logic [1:0] strapCnt_ff, nxt_strapCnt;
    logic [PRESC_W-1:0] presc_ff, nxt_presc;
    logic [LOW_STAGES-1:0] divLow_ff, nxt_divLow;
    logic [HIGH_STAGES-1:0] divHigh_ff, nxt_divHigh;
    logic [1:0] state_ff, nxt_state;
    logic [LEN_W-1:0] cyclesLeft_ff, nxt_cyclesLeft;
    logic cycleEnd_ff, nxt_cycleEnd;
    logic instrDone_ff, nxt_instrDone;
    logic resumeNext_ff, nxt_resumeNext;
    logic resumeIsr_ff, nxt_resumeIsr;
    logic dvoPrev_ff;

    // Fast oscillator runs except in slow, sleep and stop.
    function automatic logic fastOn(input scs_mode_t m);
        fastOn = (m != MODE_SLOW) && (m != MODE_SLEEP) && (m != MODE_FULL_HALT);
    endfunction : fastOn

    // Modes whose main clock comes from the low-frequency clock.
    function automatic logic slowClk(input scs_mode_t m);
        slowClk = (m == MODE_SLOW) || (m == MODE_SLEEP);
    endfunction : slowClk

    function automatic logic dualMode(input scs_mode_t m, r);
        dualMode = (m == MODE_FULL_HALT || m == MODE_WARMUP) ? (r != MODE_SINGLE_RUN) :
            (m != MODE_SINGLE_RUN) && (m != MODE_SINGLE_HALT);
    endfunction : dualMode

    logic lowCarry;
    logic stage7Tick;
    logic mainTick;
    logic cpuActive;
    logic [LEN_W-1:0] lenClamped;
    logic warmDone;

    // Timing generator: prescaler, low stages, seventh stage source.
    always_comb begin
        nxt_presc = presc_ff;
        nxt_divLow = divLow_ff;
        nxt_divHigh = divHigh_ff;
        lowCarry = 1'b0;
        if (fastOn(mode_ff)) begin
            nxt_presc = presc_ff + 2'h1;
            if (presc_ff == '1) begin
                nxt_divLow = divLow_ff + 6'h01;
                lowCarry = (divLow_ff == '1);
            end
        end
        // Seventh stage source picks per mode and select bit.
        if (slowClk(mode_ff)) begin
            stage7Tick = fsTick;
            nxt_divLow = divLow_ff;
        end else if (mode_ff == MODE_FULL_HALT) begin
            stage7Tick = 1'b0;
        end else if (mode_ff == MODE_WARMUP && slowClk(retMode_ff)) begin
            stage7Tick = fsTick;
        end else if (dualMode(mode_ff, retMode_ff) && link.timeBaseCtrl[DIVSRC_BIT]) begin
            stage7Tick = fsTick;
        end else begin
            stage7Tick = lowCarry;
        end
        if (stage7Tick) begin
            nxt_divHigh = divHigh_ff + 15'h0001;
        end
        // Stop exit clears divider stages, prescaler keeps its value.
        if (mode_ff == MODE_FULL_HALT && wakeHit) begin
            nxt_divLow = DIV_LOW_RST;
            nxt_divHigh = DIV_HIGH_RST;
        end
    end

    assign warmDone = divHigh_ff[WARM_TAP];
    assign cpuActive = (mode_ff == MODE_SINGLE_RUN) || (mode_ff == MODE_DUAL_RUN)
        || (mode_ff == MODE_SLOW);
    // Fast modes tick every clock; slow modes on each rising fs edge.
    assign mainTick = slowClk(mode_ff) ? fsTick : fastOn(mode_ff);

    // Clamp requested instruction length into the legal range.
    assign lenClamped = (link.instrLen < INSTR_MIN) ? INSTR_MIN :
        ((link.instrLen > INSTR_MAX) ? INSTR_MAX : link.instrLen);

    // Machine cycle states and instruction length counting.
    always_comb begin
        nxt_state = state_ff;
        nxt_cycleEnd = 1'b0;
        nxt_instrDone = 1'b0;
        nxt_cyclesLeft = cyclesLeft_ff;
        if (mainTick) begin
            nxt_state = state_ff + 2'h1;
            nxt_cycleEnd = (state_ff == LAST_STATE);
        end
        if (link.instrGo && cpuActive && cyclesLeft_ff == LEN_RST) begin
            nxt_cyclesLeft = lenClamped;
        end else if (mainTick && state_ff == LAST_STATE && cyclesLeft_ff != LEN_RST
                && cpuActive) begin
            nxt_cyclesLeft = cyclesLeft_ff - 4'h1;
            nxt_instrDone = (cyclesLeft_ff == 4'h1);
        end
    end

    // Standby sequencer; reset option is taken once the strap is synchronised.
    always_comb begin
        nxt_mode = mode_ff;
        nxt_retMode = retMode_ff;
        nxt_strapCnt = strapCnt_ff;
        nxt_resumeNext = 1'b0;
        nxt_resumeIsr = 1'b0;
        if (strapCnt_ff != 2'h3) begin
            nxt_strapCnt = strapCnt_ff + 2'h1;
            if (strapCnt_ff == 2'h2) begin
                nxt_mode = optSync_ff[1] ? MODE_DUAL_RUN : MODE_SINGLE_RUN;
            end
        end else begin
            unique case (mode_ff)
                MODE_SINGLE_RUN, MODE_DUAL_RUN, MODE_SLOW: begin
                    if (link.stopReq) begin
                        nxt_retMode = mode_ff;
                        nxt_mode = MODE_FULL_HALT;
                    end else if (link.idleReq) begin
                        nxt_mode = (mode_ff == MODE_SINGLE_RUN) ? MODE_SINGLE_HALT :
                            ((mode_ff == MODE_DUAL_RUN) ? MODE_DUAL_HALT : MODE_SLEEP);
                    end else if (mode_ff == MODE_DUAL_RUN && link.sysClkSel
                            && link.lowOscEnable) begin
                        nxt_mode = MODE_SLOW;
                    end else if (mode_ff == MODE_SLOW && !link.sysClkSel) begin
                        nxt_mode = MODE_DUAL_RUN;
                    end
                end
                MODE_SINGLE_HALT, MODE_DUAL_HALT, MODE_SLEEP: begin
                    if (link.intReq) begin
                        nxt_mode = (mode_ff == MODE_SINGLE_HALT) ? MODE_SINGLE_RUN :
                            ((mode_ff == MODE_DUAL_HALT) ? MODE_DUAL_RUN : MODE_SLOW);
                        nxt_resumeIsr = link.intMasterEnable;
                        nxt_resumeNext = !link.intMasterEnable;
                    end
                end
                MODE_FULL_HALT: begin
                    if (wakeHit) begin
                        nxt_mode = MODE_WARMUP;
                    end
                end
                MODE_WARMUP: begin
                    if (warmDone) begin
                        nxt_mode = retMode_ff;
                        nxt_resumeNext = 1'b1;
                    end
                end
            endcase
        end
    end

    // Registers of the sequencer and timing generator.
    always_ff @(posedge link.clk or negedge link.rst_n) begin
        if (!link.rst_n) begin
            mode_ff <= MODE_SINGLE_RUN;
            retMode_ff <= MODE_SINGLE_RUN;
            strapCnt_ff <= 2'h0;
            presc_ff <= PRESC_RST;
            divLow_ff <= DIV_LOW_RST;
            divHigh_ff <= DIV_HIGH_RST;
            state_ff <= 2'h0;
            cyclesLeft_ff <= LEN_RST;
            cycleEnd_ff <= 1'b0;
            instrDone_ff <= 1'b0;
            resumeNext_ff <= 1'b0;
            resumeIsr_ff <= 1'b0;
            dvoPrev_ff <= 1'b0;
        end else begin
            mode_ff <= nxt_mode;
            retMode_ff <= nxt_retMode;
            strapCnt_ff <= nxt_strapCnt;
            presc_ff <= nxt_presc;
            divLow_ff <= nxt_divLow;
            divHigh_ff <= nxt_divHigh;
            state_ff <= nxt_state;
            cyclesLeft_ff <= nxt_cyclesLeft;
            cycleEnd_ff <= nxt_cycleEnd;
            instrDone_ff <= nxt_instrDone;
            resumeNext_ff <= nxt_resumeNext;
            resumeIsr_ff <= nxt_resumeIsr;
            dvoPrev_ff <= divHigh_ff[0];
        end
    end

    // ----------------------------------------------------------------
    // Registered outputs
    // ----------------------------------------------------------------
    logic cpuRun_ff;
    logic wdtRun_ff;
    logic [DIV_STAGES-1:0] taps_ff;
    logic dvo_ff;
    logic highOsc_ff;
    logic lowOsc_ff;
    logic pinsPorts_ff;
    logic float_ff;

    // Outputs are flopped copies, one cycle behind the state they show.
    always_ff @(posedge link.clk or negedge link.rst_n) begin
        if (!link.rst_n) begin
            cpuRun_ff <= 1'b0;
            wdtRun_ff <= 1'b0;
            taps_ff <= '0;
            dvo_ff <= 1'b0;
            highOsc_ff <= 1'b0;
            lowOsc_ff <= 1'b0;
            pinsPorts_ff <= 1'b0;
            float_ff <= 1'b0;
        end else begin
            cpuRun_ff <= cpuActive && (strapCnt_ff == 2'h3) && !link.idleReq;
            wdtRun_ff <= cpuActive && (strapCnt_ff == 2'h3);
            taps_ff <= {divHigh_ff, divLow_ff};
            dvo_ff <= divHigh_ff[0] & ~dvoPrev_ff;
            highOsc_ff <= fastOn(mode_ff) || mode_ff == MODE_WARMUP;
            lowOsc_ff <= dualMode(mode_ff, retMode_ff) && mode_ff != MODE_FULL_HALT
                && (link.lowOscEnable || slowClk(mode_ff));
            pinsPorts_ff <= !dualMode(mode_ff, retMode_ff);
            float_ff <= (mode_ff == MODE_FULL_HALT) && link.stopFloat;
        end
    end

    assign link.cpuRun = cpuRun_ff;
    assign link.wdtRun = wdtRun_ff;
    assign link.cycleState = state_ff;
    assign link.cycleEnd = cycleEnd_ff;
    assign link.instrDone = instrDone_ff;
    assign link.mode = mode_ff;
    assign link.resumeNext = resumeNext_ff;
    assign link.resumeIsr = resumeIsr_ff;
    assign dividerTaps = taps_ff;
    assign dividerOutputPulse = dvo_ff;
    assign highOscOn = highOsc_ff;
    assign lowOscOn = lowOsc_ff;
    assign lowPinsAsPorts = pinsPorts_ff;
    assign portsFloat = float_ff;
endmodule : scs_device

// ### rtl/scs_host.sv
// CPU side end: holds the control bits and issues standby requests.
`timescale 1ns/1ns
module scs_host
    import scs_pkg::*;
(
    scs_link_if.host link,
    input wire logic [TBC_W-1:0] userTimeBase,
    input wire logic userIdle,
    input wire logic userStop,
    input wire logic userSlow,
    input wire logic userLowOscEn,
    input wire logic userWakeEdge,
    input wire logic userFloat,
    input wire logic userInt,
    input wire logic userIme,
    input wire logic userGo,
    input wire logic [LEN_W-1:0] userLen,
    output logic cpuAwake,
    output scs_mode_t modeSeen,
    output logic instrFinished
);
    // ----------------------------------------------------------------
    // Control bit registers
    // ----------------------------------------------------------------
    logic [TBC_W-1:0] tbc_ff, nxt_tbc;
    logic idle_ff, nxt_idle;
    logic stop_ff, nxt_stop;
    logic slow_ff, nxt_slow;
    logic lowEn_ff, nxt_lowEn;
    logic cfg_ff, nxt_cfg;
    logic flt_ff, nxt_flt;
    logic int_ff, nxt_int;
    logic ime_ff, nxt_ime;
    logic go_ff, nxt_go;
    logic [LEN_W-1:0] len_ff, nxt_len;
    logic awake_ff;
    scs_mode_t mode_ff;
    logic done_ff;

    // Idle, stop and go requests are one-cycle pulses, only while the CPU is running.
    always_comb begin
        nxt_tbc = userTimeBase;
        nxt_lowEn = userLowOscEn;
        // Slow is asked only with the low oscillator already enabled.
        nxt_slow = userSlow && lowEn_ff;
        nxt_cfg = userWakeEdge;
        nxt_flt = userFloat;
        nxt_int = userInt;
        nxt_ime = userIme;
        nxt_idle = userIdle && link.cpuRun && !idle_ff;
        nxt_stop = userStop && link.cpuRun && !stop_ff;
        nxt_go = userGo && link.cpuRun && !go_ff;
        nxt_len = userLen;
    end

    always_ff @(posedge link.clk or negedge link.rst_n) begin
        if (!link.rst_n) begin
            tbc_ff <= TBC_RST;
            idle_ff <= 1'b0;
            stop_ff <= 1'b0;
            slow_ff <= 1'b0;
            lowEn_ff <= 1'b0;
            cfg_ff <= 1'b0;
            flt_ff <= 1'b0;
            int_ff <= 1'b0;
            ime_ff <= 1'b0;
            go_ff <= 1'b0;
            len_ff <= LEN_RST;
            awake_ff <= 1'b0;
            mode_ff <= MODE_SINGLE_RUN;
            done_ff <= 1'b0;
        end else begin
            tbc_ff <= nxt_tbc;
            idle_ff <= nxt_idle;
            stop_ff <= nxt_stop;
            slow_ff <= nxt_slow;
            lowEn_ff <= nxt_lowEn;
            cfg_ff <= nxt_cfg;
            flt_ff <= nxt_flt;
            int_ff <= nxt_int;
            ime_ff <= nxt_ime;
            go_ff <= nxt_go;
            len_ff <= nxt_len;
            awake_ff <= link.cpuRun;
            mode_ff <= link.mode;
            done_ff <= link.instrDone;
        end
    end

    assign link.timeBaseCtrl = tbc_ff;
    assign link.idleReq = idle_ff;
    assign link.stopReq = stop_ff;
    assign link.sysClkSel = slow_ff;
    assign link.lowOscEnable = lowEn_ff;
    assign link.wakeEdgeMode = cfg_ff;
    assign link.stopFloat = flt_ff;
    assign link.intReq = int_ff;
    assign link.intMasterEnable = ime_ff;
    assign link.instrGo = go_ff;
    assign link.instrLen = len_ff;
    assign cpuAwake = awake_ff;
    assign modeSeen = mode_ff;
    assign instrFinished = done_ff;
endmodule : scs_host

// ### test/scs_link_props.sv
// Concurrent checks on the link between the clock controller and the CPU side.
`timescale 1ns/1ns
module scs_link_props
    import scs_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic idleReq,
    input wire logic stopReq,
    input wire logic sysClkSel,
    input wire logic lowOscEnable,
    input wire logic intReq,
    input wire logic intMasterEnable,
    input wire logic cpuRun,
    input wire logic wdtRun,
    input wire logic [1:0] cycleState,
    input wire scs_mode_t mode,
    input wire logic resumeNext,
    input wire logic resumeIsr
);
    // ----------------------------------------------------------------
    // One clock domain, so clock and reset are given once.
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    // Each machine cycle state lasts one fast clock while running in single-clock mode.
    property p_state_step;
        cpuRun && $past(cpuRun) && mode == MODE_SINGLE_RUN && $past(mode) == MODE_SINGLE_RUN
            |-> cycleState == $past(cycleState) + 2'h1;
    endproperty
    a_state_step: assert property (p_state_step) else $error("state step wrong");

    // Idle halts the CPU at once and the watchdog a cycle later.
    property p_idle_enter;
        cpuRun && idleReq && !stopReq && mode == MODE_SINGLE_RUN
            |=> mode == MODE_SINGLE_HALT && !cpuRun ##1 !wdtRun;
    endproperty
    a_idle_enter: assert property (p_idle_enter) else $error("idle entry wrong");

    // An interrupt with the master enable set resumes through service.
    property p_wake_isr;
        mode == MODE_SINGLE_HALT && intReq && intMasterEnable
            |=> mode == MODE_SINGLE_RUN && resumeIsr ##1 cpuRun;
    endproperty
    a_wake_isr: assert property (p_wake_isr) else $error("idle exit to service wrong");

    // With the master enable clear, execution resumes at the next instruction.
    property p_wake_next;
        mode == MODE_SINGLE_HALT && intReq && !intMasterEnable
            |=> mode == MODE_SINGLE_RUN && resumeNext && !resumeIsr;
    endproperty
    a_wake_next: assert property (p_wake_next) else $error("idle exit to next wrong");

    // Dual idle returns to dual run.
    property p_dual_back;
        mode == MODE_DUAL_HALT && intReq |=> mode == MODE_DUAL_RUN;
    endproperty
    a_dual_back: assert property (p_dual_back) else $error("dual idle exit wrong");

    // Sleep returns to slow.
    property p_sleep_back;
        mode == MODE_SLEEP && intReq |=> mode == MODE_SLOW;
    endproperty
    a_sleep_back: assert property (p_sleep_back) else $error("sleep exit wrong");

    // A stop request from any run mode halts everything.
    property p_stop_enter;
        cpuRun && stopReq |=> mode == MODE_FULL_HALT;
    endproperty
    a_stop_enter: assert property (p_stop_enter) else $error("stop entry wrong");

    // Nothing runs while stopped.
    property p_stop_quiet;
        mode == MODE_FULL_HALT && $past(mode) == MODE_FULL_HALT |-> !cpuRun && !wdtRun;
    endproperty
    a_stop_quiet: assert property (p_stop_quiet) else $error("activity while stopped");

    // Slow is refused until the low oscillator has been enabled.
    property p_slow_refuse;
        mode == MODE_DUAL_RUN && !lowOscEnable |=> mode != MODE_SLOW;
    endproperty
    a_slow_refuse: assert property (p_slow_refuse) else $error("slow without oscillator");

    // Slow is entered one cycle after a legal request.
    property p_slow_go;
        cpuRun && mode == MODE_DUAL_RUN && sysClkSel && lowOscEnable && !idleReq && !stopReq
            |=> mode == MODE_SLOW;
    endproperty
    a_slow_go: assert property (p_slow_go) else $error("slow entry wrong");
endmodule : scs_link_props

// ### test/system_clock_standby_controller_tb_top.sv
// Bench joining both ends over the link and driving the CPU side inputs.
`timescale 1ns/1ns
module system_clock_standby_controller_tb_top;
    import scs_pkg::*;
    logic clk = 1'h0, rst_n = 1'h0, dualOption = 1'h0, lowFreqPin = 1'h0, wakePin = 1'h0;
    logic userIdle = 1'h0, userStop = 1'h0, userSlow = 1'h0, userLowOscEn = 1'h0;
    logic userFloat = 1'h0, userInt = 1'h0, userIme = 1'h0, userGo = 1'h0;
    logic [TBC_W-1:0] userTimeBase = 8'h00;
    logic [LEN_W-1:0] userLen = 4'h1;
    logic [DIV_STAGES-1:0] dividerTaps;
    logic highOscOn, lowOscOn, lowPinsAsPorts, portsFloat, sawIsr, sawNext;
    logic [5:0] taps;
    logic [LEN_W-1:0] lens [3] = '{4'h1, 4'hA, 4'hC};
    int errors = 0, nCompared = 0, cycles = 0, n, expLen;

    // ----------------------------------------------------------------
    // Clocks, ends and checker.
    // ----------------------------------------------------------------
    // The low clock free-runs on its pin, unrelated in phase to clk.
    always #5 clk = ~clk;
    always #83 lowFreqPin = ~lowFreqPin;
    scs_link_if link (.clk(clk), .rst_n(rst_n));
    scs_device u_scs_device (.link(link), .dualOption(dualOption), .lowFreqPin(lowFreqPin),
        .wakePin(wakePin), .dividerTaps(dividerTaps), .dividerOutputPulse(),
        .highOscOn(highOscOn), .lowOscOn(lowOscOn), .lowPinsAsPorts(lowPinsAsPorts),
        .portsFloat(portsFloat));
    scs_host u_scs_host (.link(link), .userTimeBase(userTimeBase), .userIdle(userIdle),
        .userStop(userStop), .userSlow(userSlow), .userLowOscEn(userLowOscEn),
        .userWakeEdge(1'h0), .userFloat(userFloat), .userInt(userInt), .userIme(userIme),
        .userGo(userGo), .userLen(userLen), .cpuAwake(), .modeSeen(), .instrFinished());
    scs_link_props u_scs_link_props (.clk(clk), .rst_n(rst_n), .idleReq(link.idleReq),
        .stopReq(link.stopReq), .sysClkSel(link.sysClkSel), .lowOscEnable(link.lowOscEnable),
        .intReq(link.intReq), .intMasterEnable(link.intMasterEnable), .cpuRun(link.cpuRun),
        .wdtRun(link.wdtRun), .cycleState(link.cycleState), .mode(link.mode),
        .resumeNext(link.resumeNext), .resumeIsr(link.resumeIsr));

    // Resume pulses last one cycle, so they are latched here; a hang ends the run.
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (link.resumeIsr === 1'h1) sawIsr <= 1'h1;
        if (link.resumeNext === 1'h1) sawNext <= 1'h1;
        if (cycles == 20000) begin
            errors++;
            complete_run();
        end
    end

    // ----------------------------------------------------------------
    // Tasks.
    // ----------------------------------------------------------------
    task automatic tick(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask : tick

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        nCompared++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : check

    // Requests are spaced two cycles apart, as the host expects.
    task automatic pulse(ref logic s);
        s = 1'h1;
        tick(1);
        s = 1'h0;
        tick(2);
    endtask : pulse

    task automatic wait_mode(input scs_mode_t m, input int lim);
        n = 0;
        while (link.mode !== m && n < lim) begin
            tick(1);
            n++;
        end
        check("mode", {13'h0, link.mode}, {13'h0, m});
    endtask : wait_mode

    task automatic do_reset(input logic dual);
        rst_n = 1'h0;
        dualOption = dual;
        tick(16);
        rst_n = 1'h1;
        n = 0;
        while (link.cpuRun !== 1'h1 && n < 20) begin
            tick(1);
            n++;
        end
        check("cpuRun", {15'h0, link.cpuRun}, 16'h0001);
    endtask : do_reset

    task automatic complete_run;
        $display("compared %0d mismatches %0d", nCompared, errors);
        if (errors == 0 && nCompared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : complete_run

    // ----------------------------------------------------------------
    // Tests.
    // ----------------------------------------------------------------
    initial begin
        do_reset(1'h0);
        check("mode", {13'h0, link.mode}, {13'h0, MODE_SINGLE_RUN});
        check("ports", {15'h0, lowPinsAsPorts}, 16'h0001);
        check("lowOsc", {15'h0, lowOscOn}, 16'h0000);
        // Shortest, longest and an over-long length that must clamp to ten.
        foreach (lens[i]) begin
            userLen = lens[i];
            userGo = 1'h1;
            tick(1);
            userGo = 1'h0;
            n = 0;
            while (link.instrDone !== 1'h1 && n < 60) begin
                tick(1);
                n++;
            end
            expLen = 4 * ((lens[i] > 4'hA) ? 10 : int'(lens[i]));
            check("instrLen", {15'h0, n >= expLen - 4 && n <= expLen + 3}, 16'h0001);
            tick(2);
        end
        $display("test instruction lengths done");
        for (int ime = 0; ime < 2; ime++) begin
            userIme = ime[0];
            pulse(userIdle);
            check("halt", {13'h0, link.mode}, {13'h0, MODE_SINGLE_HALT});
            check("cpuRun", {15'h0, link.cpuRun}, 16'h0000);
            sawIsr = 1'h0;
            sawNext = 1'h0;
            userInt = 1'h1;
            wait_mode(MODE_SINGLE_RUN, 10);
            userInt = 1'h0;
            tick(2);
            check("isr", {15'h0, sawIsr}, {15'h0, ime[0]});
            check("next", {15'h0, sawNext}, {15'h0, !ime[0]});
        end
        $display("test idle done");
        userFloat = 1'h1;
        pulse(userStop);
        tick(2);
        check("stop", {13'h0, link.mode}, {13'h0, MODE_FULL_HALT});
        check("highOsc", {15'h0, highOscOn}, 16'h0000);
        check("float", {14'h0, portsFloat, lowPinsAsPorts}, 16'h0003);
        wakePin = 1'h1;
        wait_mode(MODE_WARMUP, 10);
        wakePin = 1'h0;
        userFloat = 1'h0;
        wait_mode(MODE_SINGLE_RUN, 5000);
        check("warmup", {15'h0, n >= 4088 && n <= 4104}, 16'h0001);
        $display("test stop done");
        // Second reset in mid-run, now with the dual-clock option.
        do_reset(1'h1);
        check("mode", {13'h0, link.mode}, {13'h0, MODE_DUAL_RUN});
        check("ports", {15'h0, lowPinsAsPorts}, 16'h0000);
        userSlow = 1'h1;
        tick(6);
        check("refuse", {13'h0, link.mode}, {13'h0, MODE_DUAL_RUN});
        userLowOscEn = 1'h1;
        wait_mode(MODE_SLOW, 10);
        tick(1);
        check("highOsc", {15'h0, highOscOn}, 16'h0000);
        taps = dividerTaps[5:0];
        tick(40);
        check("lowStages", {10'h0, dividerTaps[5:0]}, {10'h0, taps});
        pulse(userIdle);
        wait_mode(MODE_SLEEP, 40);
        userInt = 1'h1;
        wait_mode(MODE_SLOW, 40);
        userInt = 1'h0;
        userSlow = 1'h0;
        wait_mode(MODE_DUAL_RUN, 40);
        tick(2);
        pulse(userIdle);
        check("dualHalt", {13'h0, link.mode}, {13'h0, MODE_DUAL_HALT});
        userInt = 1'h1;
        wait_mode(MODE_DUAL_RUN, 10);
        userInt = 1'h0;
        $display("test dual clock done");
        tick(4);
        complete_run();
    end
endmodule : system_clock_standby_controller_tb_top
